/* core/pts_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Stamping, capture and flag setting happen only while the enable bit is one.
// - Each transmitted frame returns timer value, 4-bit sequence tag and status.
// - Status bit 5 equals the stamp request seen with that frame.
// - Requested frames load the held stamp register and set stamp-ready.
// - Unrequested frames touch neither the held stamp nor stamp-ready.
// - Every received frame latches the timer at delimiter detection.
// - The stamp of each received frame is written into its descriptor.
// - Event flags clear on writing one, ignore zero, reset to zero.
// - Interrupt is raised while any flag and its mask bit are both set.
module pts_top (
	input  wire logic                   REF_CLK,
	input  wire logic                   RST,
	input  wire logic [7:0]             S_AXI_AWADDR,
	input  wire logic                   S_AXI_AWVALID,
	output logic                        S_AXI_AWREADY,
	input  wire logic [31:0]            S_AXI_WDATA,
	input  wire logic [3:0]             S_AXI_WSTRB,
	input  wire logic                   S_AXI_WVALID,
	output logic                        S_AXI_WREADY,
	output logic [1:0]                  S_AXI_BRESP,
	output logic                        S_AXI_BVALID,
	input  wire logic                   S_AXI_BREADY,
	input  wire logic [7:0]             S_AXI_ARADDR,
	input  wire logic                   S_AXI_ARVALID,
	output logic                        S_AXI_ARREADY,
	output logic [31:0]                 S_AXI_RDATA,
	output logic [1:0]                  S_AXI_RRESP,
	output logic                        S_AXI_RVALID,
	input  wire logic                   S_AXI_RREADY,
	input  wire logic                   TX_SOF,
	input  wire logic                   TX_STAMP_REQUEST,
	output pts_pkg::pts_tx_stamp_t      TX_STAMP,
	input  wire logic                   RX_SFD,
	output logic [31:0]                 RX_STAMP_VALUE,
	output logic                        RX_STAMP_VALID,
	input  wire logic                   RX_FRAME_END,
	output logic                        RX_DESC_STAMP_WE,
	output logic [31:0]                 RX_DESC_STAMP,
	output logic                        IRQ
);
	import pts_pkg::*;

	pts_top_st_t       s_r, s_nxt;
	logic              wr_en;
	logic [7:0]        wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              wr_err;
	logic [7:0]        rd_addr;
	logic [31:0]       rd_data;
	logic              rd_err;
	logic [31:0]       tmr_count;
	logic              tmr_wrap;
	logic              tmr_load;
	logic [31:0]       wmask;
	logic [NFLAGS-1:0] ev_set;
	logic [NFLAGS-1:0] ev_clr;
	logic              tx_req_ev;

	pts_axil u_bus (
		.clk     (REF_CLK),
		.rst     (RST),
		.awaddr  (S_AXI_AWADDR),
		.awvalid (S_AXI_AWVALID),
		.awready (S_AXI_AWREADY),
		.wdata   (S_AXI_WDATA),
		.wstrb   (S_AXI_WSTRB),
		.wvalid  (S_AXI_WVALID),
		.wready  (S_AXI_WREADY),
		.bresp   (S_AXI_BRESP),
		.bvalid  (S_AXI_BVALID),
		.bready  (S_AXI_BREADY),
		.araddr  (S_AXI_ARADDR),
		.arvalid (S_AXI_ARVALID),
		.arready (S_AXI_ARREADY),
		.rdata   (S_AXI_RDATA),
		.rresp   (S_AXI_RRESP),
		.rvalid  (S_AXI_RVALID),
		.rready  (S_AXI_RREADY),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_err  (wr_err),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_err  (rd_err)
	);

	// Byte lanes of the write; the timer load honours them against the live count
	assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	assign tmr_load = wr_en && (wr_addr == OFS_TIMER);

	pts_timer #(
		.CW (32)
	) u_timer (
		.clk      (REF_CLK),
		.rst      (RST),
		.load     (tmr_load),
		.load_val ((tmr_count & ~wmask) | (wr_data & wmask)),
		.incr     (s_r.incr),
		.corr_per (s_r.corr_per),
		.corr_inc (s_r.corr_inc),
		.count    (tmr_count),
		.wrap     (tmr_wrap)
	);

	// Hardware events that raise flags, gated by the enable bit
	assign tx_req_ev = TX_SOF && TX_STAMP_REQUEST && s_r.en;
	always_comb begin
		ev_set = '0;
		ev_set[FLAG_READY] = tx_req_ev;
		ev_set[FLAG_WRAP] = tmr_wrap && s_r.en;
		ev_clr = '0;
		if (wr_en && wr_addr == OFS_FLAGS) begin
			ev_clr = wr_data[NFLAGS-1:0] & wmask[NFLAGS-1:0];
		end
	end

	// Register read mux; unmapped offsets answer SLVERR
	always_comb begin
		rd_data = 32'h0;
		rd_err = 1'b0;
		unique case (rd_addr)
			OFS_CTRL:     rd_data[CTRL_EN_BIT] = s_r.en;
			OFS_FLAGS:    rd_data[NFLAGS-1:0] = s_r.flags;
			OFS_MASK:     rd_data[NFLAGS-1:0] = s_r.mask;
			OFS_HELD:     rd_data = s_r.held;
			OFS_TIMER:    rd_data = tmr_count;
			OFS_INCR:     rd_data = s_r.incr;
			OFS_CORR_PER: rd_data = s_r.corr_per;
			OFS_CORR_INC: rd_data = s_r.corr_inc;
			OFS_RX_LAST:  rd_data = s_r.rx_stamp;
			default:      rd_err = 1'b1;
		endcase
	end

	// Writes to read-only or unmapped offsets are refused with SLVERR
	always_comb begin
		unique case (wr_addr)
			OFS_CTRL, OFS_FLAGS, OFS_MASK, OFS_TIMER,
			OFS_INCR, OFS_CORR_PER, OFS_CORR_INC: wr_err = 1'b0;
			default:                              wr_err = 1'b1;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		// Register writes
		if (wr_en) begin
			unique case (wr_addr)
				OFS_CTRL: begin
					if (wr_strb[0]) begin
						s_nxt.en = wr_data[CTRL_EN_BIT];
					end
				end
				OFS_MASK: begin
					s_nxt.mask = (s_r.mask & ~wmask[NFLAGS-1:0]) |
						(wr_data[NFLAGS-1:0] & wmask[NFLAGS-1:0]);
				end
				OFS_INCR:     s_nxt.incr = (s_r.incr & ~wmask) | (wr_data & wmask);
				OFS_CORR_PER: s_nxt.corr_per = (s_r.corr_per & ~wmask) | (wr_data & wmask);
				OFS_CORR_INC: s_nxt.corr_inc = (s_r.corr_inc & ~wmask) | (wr_data & wmask);
				default: begin
				end
			endcase
		end
		// A flag set in the clearing cycle survives: set wins over clear
		s_nxt.flags = (s_r.flags & ~ev_clr) | ev_set;
		// Transmit stamp returned one cycle after frame start
		s_nxt.tx.valid = TX_SOF && s_r.en;
		if (TX_SOF && s_r.en) begin
			s_nxt.tx.value = tmr_count;
			s_nxt.tx.seq_tag = s_r.seq;
			s_nxt.tx.status = '0;
			s_nxt.tx.status[STAT_REQ_BIT] = TX_STAMP_REQUEST;
			s_nxt.seq = s_r.seq + 4'h1;
		end
		// Held copy only for requested frames, so unrequested frames never disturb a pending value; a later requested frame overwrites it
		if (tx_req_ev) begin
			s_nxt.held = tmr_count;
		end
		// Receive capture at delimiter and descriptor write at frame end
		s_nxt.rx_valid = RX_SFD && s_r.en;
		s_nxt.desc_we = RX_FRAME_END && s_r.rx_pending;
		if (RX_FRAME_END && s_r.rx_pending) begin
			s_nxt.desc_stamp = s_r.rx_stamp;
			s_nxt.rx_pending = 1'b0;
		end
		if (RX_SFD && s_r.en) begin
			s_nxt.rx_stamp = tmr_count;
			s_nxt.rx_pending = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			s_r <= '0;
			s_r.incr <= RST_INCR;
			s_r.corr_per <= RST_CORR_PER;
			s_r.corr_inc <= RST_CORR_INC;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign TX_STAMP = s_r.tx;
	assign RX_STAMP_VALUE = s_r.rx_stamp;
	assign RX_STAMP_VALID = s_r.rx_valid;
	assign RX_DESC_STAMP_WE = s_r.desc_we;
	assign RX_DESC_STAMP = s_r.desc_stamp;
	assign IRQ = |(s_r.flags & s_r.mask);

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	// Enable gates the captures, the tag step and the flag setting; the timer keeps running so time stays continuous

	AST_DIS_NO_TX: assert property (TX_SOF && !s_r.en |=> !TX_STAMP.valid && $stable(s_r.held))
		else $error("stamp produced while disabled");
	AST_TX_RETURN: assert property (TX_SOF && s_r.en |=>
		TX_STAMP.valid && TX_STAMP.value == $past(tmr_count) && TX_STAMP.seq_tag == $past(s_r.seq))
		else $error("transmit stamp not returned with captured time");
	AST_TX_STATUS: assert property (TX_STAMP.valid |->
		TX_STAMP.status[STAT_REQ_BIT] == $past(TX_STAMP_REQUEST))
		else $error("status bit does not match request");

	// Held copy and ready flag move together so software never reads a stale stamp
	AST_HELD_LOAD: assert property (tx_req_ev |=> s_r.held == $past(tmr_count) && s_r.flags[FLAG_READY])
		else $error("held stamp or ready flag not updated");
	AST_HELD_KEEP: assert property (TX_SOF && !TX_STAMP_REQUEST && !s_r.flags[FLAG_READY]
		&& !tmr_wrap |=> $stable(s_r.held) && !s_r.flags[FLAG_READY])
		else $error("unrequested frame disturbed held stamp");

	// Receive side: capture at the delimiter, hand over at frame end
	AST_RX_LATCH: assert property (RX_SFD && s_r.en |=>
		RX_STAMP_VALID && RX_STAMP_VALUE == $past(tmr_count))
		else $error("receive stamp not latched at delimiter");
	AST_DESC_COPY: assert property (RX_FRAME_END && s_r.rx_pending |=>
		RX_DESC_STAMP_WE && RX_DESC_STAMP == $past(RX_STAMP_VALUE))
		else $error("descriptor stamp not written");

	// Flag register: write one clears, a coincident event wins
	AST_W1C: assert property (ev_clr[FLAG_READY] && !ev_set[FLAG_READY] |=> !s_r.flags[FLAG_READY])
		else $error("write one did not clear flag");
	AST_SET_WINS: assert property (ev_set[FLAG_READY] && ev_clr[FLAG_READY]
		|=> s_r.flags[FLAG_READY])
		else $error("flag set lost to clear");
	AST_IRQ: assert property (ev_set[FLAG_READY] && s_r.mask[FLAG_READY] && !(wr_en && wr_addr == OFS_MASK)
		|=> IRQ)
		else $error("masked-in event raised no interrupt");

	// A refused frame must not advance the tag, or the client pairs stamps wrongly
	AST_DIS_NO_SEQ: assert property (TX_SOF && !s_r.en |=> $stable(s_r.seq))
		else $error("sequence tag advanced while disabled");

	// Delimiters seen while disabled leave the receive capture untouched
	AST_DIS_NO_RX: assert property (RX_SFD && !s_r.en
		|=> !RX_STAMP_VALID && $stable(RX_STAMP_VALUE))
		else $error("receive stamp captured while disabled");

	// Tag steps by one per enabled frame and wraps after sixteen
	AST_SEQ_STEP: assert property (TX_SOF && s_r.en
		|=> s_r.seq == $past(s_r.seq) + 4'h1)
		else $error("sequence tag did not step");

	// No frame start, no stamp; the returned value stands until the next frame
	AST_TX_PULSE: assert property (!TX_SOF |=> !TX_STAMP.valid)
		else $error("stamp returned without a frame");
	AST_TX_KEEP: assert property (!TX_SOF |=> $stable(TX_STAMP.value))
		else $error("returned stamp changed between frames");

	// Status carries the request bit only; the others stay zero
	AST_TX_STAT_ZERO: assert property (TX_STAMP.valid |->
		TX_STAMP.status[4:0] == 5'h00 && TX_STAMP.status[7:6] == 2'h0)
		else $error("reserved status bits set");

	// Only a requested frame may move the held copy; bus writes to it are refused
	AST_HELD_ONLY_REQ: assert property (!tx_req_ev |=> $stable(s_r.held))
		else $error("held stamp changed without a requested frame");

	// Without a set or a clear the ready flag keeps its value
	AST_FLAG_HOLD: assert property (!ev_set[FLAG_READY] && !ev_clr[FLAG_READY]
		|=> $stable(s_r.flags[FLAG_READY]))
		else $error("ready flag moved on its own");

	// Timer carry raises the wrap flag while enabled
	AST_WRAP_FLAG: assert property (tmr_wrap && s_r.en |=> s_r.flags[FLAG_WRAP])
		else $error("timer wrap not flagged");

	// A delimiter arms the descriptor write; a frame end with nothing armed writes none
	AST_RX_ARM: assert property (RX_SFD && s_r.en |=> s_r.rx_pending)
		else $error("delimiter did not arm descriptor write");
	AST_DESC_IDLE: assert property (!(RX_FRAME_END && s_r.rx_pending)
		|=> !RX_DESC_STAMP_WE)
		else $error("descriptor written without a capture");

	COV_TX_REQ:  cover property (tx_req_ev ##1 TX_STAMP.valid);
	COV_RX_DESC: cover property (RX_SFD && s_r.en ##[1:50] RX_DESC_STAMP_WE);
	COV_CLEAR:   cover property (s_r.flags[FLAG_READY] ##1 !s_r.flags[FLAG_READY]);
	COV_IRQ:     cover property (IRQ);
	COV_SET_CLR: cover property (ev_set[FLAG_READY] && ev_clr[FLAG_READY]);
endmodule
`default_nettype wire

/* core/pts_pkg.sv */
package pts_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_FLAGS     = 8'h04;
	localparam logic [7:0]  OFS_MASK      = 8'h08;
	localparam logic [7:0]  OFS_HELD      = 8'h0c;
	localparam logic [7:0]  OFS_TIMER     = 8'h10;
	localparam logic [7:0]  OFS_INCR      = 8'h14;
	localparam logic [7:0]  OFS_CORR_PER  = 8'h18;
	localparam logic [7:0]  OFS_CORR_INC  = 8'h1c;
	localparam logic [7:0]  OFS_RX_LAST   = 8'h20;
	// Field positions and flag count
	localparam int          CTRL_EN_BIT   = 0;
	localparam int          FLAG_READY    = 0;
	localparam int          FLAG_WRAP     = 1;
	localparam int          NFLAGS        = 2;
	localparam int          STAT_REQ_BIT  = 5;
	// Values after reset, and AXI response codes
	localparam logic [31:0] RST_INCR      = 32'h0000_0004;
	localparam logic [31:0] RST_CORR_PER  = 32'h0000_0000;
	localparam logic [31:0] RST_CORR_INC  = 32'h0000_0004;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;

	// Transmit stamp returned for each frame
	typedef struct packed {
		logic        valid;
		logic [31:0] value;
		logic [3:0]  seq_tag;
		logic [7:0]  status;
	} pts_tx_stamp_t;

	typedef struct packed {
		logic        aw_have;
		logic        w_have;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pts_axil_st_t;

	typedef struct packed {
		logic [31:0] count;
		logic [31:0] per_cnt;
		logic        wrap;
	} pts_timer_st_t;

	typedef struct packed {
		logic              en;
		logic [NFLAGS-1:0] flags;
		logic [NFLAGS-1:0] mask;
		logic [31:0]       held;
		logic [31:0]       incr;
		logic [31:0]       corr_per;
		logic [31:0]       corr_inc;
		pts_tx_stamp_t     tx;
		logic [3:0]        seq;
		logic [31:0]       rx_stamp;
		logic              rx_valid;
		logic              rx_pending;
		logic              desc_we;
		logic [31:0]       desc_stamp;
	} pts_top_st_t;
endpackage

/* core/pts_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module pts_timer #(
	parameter int CW = 32
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          load,
	input  wire logic [CW-1:0] load_val,
	input  wire logic [CW-1:0] incr,
	input  wire logic [31:0]   corr_per,
	input  wire logic [CW-1:0] corr_inc,
	output logic      [CW-1:0] count,
	output logic               wrap
);
	import pts_pkg::*;

	// Counter state lives in the shared package struct, so width is fixed there
	if (CW != 32) begin : g_chk
		$error("pts_timer supports CW of 32 only");
	end

	pts_timer_st_t s_r, s_nxt;
	logic [CW:0]   sum;
	logic          corr_now;

	// Every corr_per cycles the correction increment replaces the nominal one
	always_comb begin
		s_nxt = s_r;
		corr_now = (corr_per != 32'h0) && (s_r.per_cnt >= corr_per - 32'h1);
		sum = {1'b0, s_r.count} + {1'b0, (corr_now ? corr_inc : incr)};
		s_nxt.per_cnt = corr_now ? 32'h0 : s_r.per_cnt + 32'h1;
		s_nxt.count = sum[CW-1:0];
		s_nxt.wrap = sum[CW] && !load;
		// A software load wins over the step in the same cycle
		if (load) begin
			s_nxt.count = load_val;
			s_nxt.per_cnt = 32'h0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign count = s_r.count;
	assign wrap  = s_r.wrap;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_TMR_STEP: assert property (!load && !corr_now |=> count == $past(count) + $past(incr))
		else $error("timer did not step by the nominal increment");
	AST_TMR_LOAD: assert property (load |=> count == $past(load_val))
		else $error("timer load value not taken");
endmodule
`default_nettype wire

/* core/pts_axil.sv */
`timescale 1ns/1ns
`default_nettype none
module pts_axil (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             wr_en,
	output logic [7:0]       wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	input  wire logic        wr_err,
	output logic [7:0]       rd_addr,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_err
);
	import pts_pkg::*;

	pts_axil_st_t s_r, s_nxt;

	// Address and data are taken in either order; no new write until B is taken
	assign awready = !s_r.aw_have && !s_r.bvalid;
	assign wready  = !s_r.w_have && !s_r.bvalid;
	assign arready = !s_r.rvalid;
	assign wr_en   = s_r.aw_have && s_r.w_have && !s_r.bvalid;
	assign wr_addr = s_r.awaddr;
	assign wr_data = s_r.wdata;
	assign wr_strb = s_r.wstrb;
	assign rd_addr = araddr;

	always_comb begin
		s_nxt = s_r;
		if (awvalid && awready) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.awaddr = awaddr;
		end
		if (wvalid && wready) begin
			s_nxt.w_have = 1'b1;
			s_nxt.wdata = wdata;
			s_nxt.wstrb = wstrb;
		end
		if (wr_en) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_r.bvalid && bready) begin
			s_nxt.bvalid = 1'b0;
		end
		// Read data registered at the address handshake
		if (arvalid && arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = rd_data;
			s_nxt.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_r.rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign bvalid = s_r.bvalid;
	assign bresp  = s_r.bresp;
	assign rvalid = s_r.rvalid;
	assign rdata  = s_r.rdata;
	assign rresp  = s_r.rresp;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_AXI_BHOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before bready");
	AST_AXI_RLAT: assert property (arvalid && arready |=> rvalid)
		else $error("read answer not one edge after address");
endmodule
`default_nettype wire

/* verif/pts_mac_client.sv */
`timescale 1ns/1ns
`default_nettype none
// Frame client and receive DMA standing on the far side of the stamping unit
module pts_mac_client (
	input  wire logic                   clk,
	output logic                        tx_sof,
	output logic                        tx_stamp_request,
	input  wire pts_pkg::pts_tx_stamp_t tx_stamp,
	output logic                        rx_sfd,
	output logic                        rx_frame_end,
	input  wire logic                   desc_we,
	input  wire logic [31:0]            desc_stamp
);
	import pts_pkg::*;
	pts_tx_stamp_t tx_log[$];
	logic [31:0]   desc_log[$];

	// Quiet lines from time zero so nothing is captured during reset
	initial begin
		tx_sof = 1'b0;
		tx_stamp_request = 1'b0;
		rx_sfd = 1'b0;
		rx_frame_end = 1'b0;
	end

	// Client collects each returned stamp, DMA stores each descriptor word
	always @(posedge clk) begin
		if (tx_stamp.valid === 1'b1)
			tx_log.push_back(tx_stamp);
		if (desc_we === 1'b1)
			desc_log.push_back(desc_stamp);
	end

	// Back-to-back frames; request bit i marks frame i as an event frame
	task automatic send(input int n, input logic [7:0] req, input logic sfd);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			tx_sof <= 1'b1;
			tx_stamp_request <= req[i];
			rx_sfd <= sfd && (i == 0);
		end
		@(posedge clk);
		tx_sof <= 1'b0;
		tx_stamp_request <= 1'b0;
		rx_sfd <= 1'b0;
	endtask

	// End of the received frame, one cycle pulse
	task automatic frame_end();
		@(posedge clk);
		rx_frame_end <= 1'b1;
		@(posedge clk);
		rx_frame_end <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* verif/tb_pts_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_pts_top;
	import pts_pkg::*;
	logic          clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]    awaddr, araddr;
	logic [31:0]   wdata;
	logic [3:0]    wstrb;
	logic          awready, wready, bvalid, arready, rvalid, rx_valid, desc_we, irq;
	logic [1:0]    bresp, rresp;
	logic [31:0]   rdata, rx_value, desc_stamp;
	logic          tx_sof, tx_req, rx_sfd, rx_end;
	pts_tx_stamp_t tx_stamp, sa, sb;
	int            fails, cmp_count;
	int            rx_pulses = 0;

	pts_top DUT (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.TX_SOF(tx_sof), .TX_STAMP_REQUEST(tx_req), .TX_STAMP(tx_stamp), .RX_SFD(rx_sfd),
		.RX_STAMP_VALUE(rx_value), .RX_STAMP_VALID(rx_valid), .RX_FRAME_END(rx_end),
		.RX_DESC_STAMP_WE(desc_we), .RX_DESC_STAMP(desc_stamp), .IRQ(irq));

	pts_mac_client MAC (.clk(clk), .tx_sof(tx_sof), .tx_stamp_request(tx_req),
		.tx_stamp(tx_stamp), .rx_sfd(rx_sfd), .rx_frame_end(rx_end), .desc_we(desc_we),
		.desc_stamp(desc_stamp));

	// Count receive capture pulses; each enabled delimiter must give exactly one
	always @(posedge clk)
		if (rx_valid === 1'b1)
			rx_pulses++;

	// 250 MHz reference clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic finish_test();
		if (fails == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// A spent bound counts as a mismatch and ends the run
	task automatic timeout(input int n);
		if (n >= 60) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, n, 0);
			finish_test();
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 60);
		timeout(n);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	// Read and compare; data only judged when an OKAY answer is expected
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 60);
		timeout(n);
		rready <= 1'b0;
		chk({30'h0, rresp}, {30'h0, er});
		if (er == RESP_OKAY)
			chk(rdata, e);
	endtask

	task automatic wait_tx(input int cnt);
		int n;
		for (n = 0; n < 60 && MAC.tx_log.size() != cnt; n++)
			@(posedge clk);
		timeout(n);
	endtask

	// Register reset values, read-only and unmapped places
	task automatic t_reset();
		rd(OFS_CTRL, 32'h0, RESP_OKAY);
		rd(OFS_FLAGS, 32'h0, RESP_OKAY);
		rd(OFS_INCR, RST_INCR, RESP_OKAY);
		rd(OFS_CORR_INC, RST_CORR_INC, RESP_OKAY);
		rd(8'h24, 32'h0, RESP_SLVERR);
		wr(OFS_HELD, 32'h5a5a_5a5a, RESP_SLVERR);
		rd(OFS_HELD, 32'h0, RESP_OKAY);
	endtask

	// Disabled: an event frame with a delimiter leaves no trace
	task automatic t_disabled();
		MAC.send(1, 8'h01, 1'b1);
		repeat (4) @(posedge clk);
		chk(MAC.tx_log.size(), 32'h0);
		chk(rx_value, 32'h0);
		chk(rx_pulses, 32'h0);
		rd(OFS_FLAGS, 32'h0, RESP_OKAY);
	endtask

	// Plain then event frame, flag handling and interrupt
	task automatic t_single();
		wr(OFS_CTRL, 32'h1, RESP_OKAY);
		MAC.send(1, 8'h00, 1'b0);
		wait_tx(1);
		chk({28'h0, MAC.tx_log[0].seq_tag}, 32'h0);
		chk({24'h0, MAC.tx_log[0].status}, 32'h0);
		rd(OFS_HELD, 32'h0, RESP_OKAY);
		rd(OFS_FLAGS, 32'h0, RESP_OKAY);
		MAC.send(1, 8'h01, 1'b0);
		wait_tx(2);
		sa = MAC.tx_log[1];
		chk({28'h0, sa.seq_tag}, 32'h1);
		chk({24'h0, sa.status}, 32'h20);
		rd(OFS_FLAGS, 32'h1, RESP_OKAY);
		rd(OFS_HELD, sa.value, RESP_OKAY);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_MASK, 32'h1, RESP_OKAY);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_FLAGS, 32'h0, RESP_OKAY);
		rd(OFS_FLAGS, 32'h1, RESP_OKAY);
		wr(OFS_FLAGS, 32'h1, RESP_OKAY);
		rd(OFS_FLAGS, 32'h0, RESP_OKAY);
		chk({31'h0, irq}, 32'h0);
		// Clear lands in the very cycle of a new event frame: the event wins
		fork
			wr(OFS_FLAGS, 32'h1, RESP_OKAY);
			begin
				@(posedge clk);
				MAC.send(1, 8'h01, 1'b0);
			end
		join
		wait_tx(3);
		rd(OFS_FLAGS, 32'h1, RESP_OKAY);
		chk({31'h0, irq}, 32'h1);
	endtask

	// Back-to-back frames, receive stamp on the same instant, descriptor
	task automatic t_burst();
		MAC.send(2, 8'h01, 1'b1);
		wait_tx(5);
		sa = MAC.tx_log[3];
		sb = MAC.tx_log[4];
		chk({28'h0, sb.seq_tag}, 32'h4);
		chk({24'h0, sb.status}, 32'h0);
		chk(sb.value - sa.value, RST_INCR);
		chk(rx_value, sa.value);
		chk(rx_pulses, 32'h1);
		rd(OFS_HELD, sa.value, RESP_OKAY);
		MAC.frame_end();
		repeat (3) @(posedge clk);
		chk(MAC.desc_log.size(), 32'h1);
		chk(MAC.desc_log[0], sa.value);
		rd(OFS_RX_LAST, sa.value, RESP_OKAY);
	endtask

	// A loaded timer value shows up in the next stamp
	task automatic t_load();
		wr(OFS_TIMER, 32'h8000_0000, RESP_OKAY);
		MAC.send(1, 8'h00, 1'b0);
		wait_tx(6);
		chk({28'h0, MAC.tx_log[5].value[31:28]}, 32'h8);
		// Loading near the top makes the timer carry out a few cycles later
		wr(OFS_TIMER, 32'hffff_ffe0, RESP_OKAY);
		repeat (10) @(posedge clk);
		rd(OFS_FLAGS, 32'h3, RESP_OKAY);
		// Every second step takes the correction increment instead of the nominal one
		wr(OFS_CORR_INC, 32'h8, RESP_OKAY);
		wr(OFS_CORR_PER, 32'h2, RESP_OKAY);
		MAC.send(3, 8'h00, 1'b0);
		wait_tx(9);
		chk(MAC.tx_log[8].value - MAC.tx_log[6].value, RST_INCR + 32'h8);
	endtask

	initial begin
		fails = 0;
		cmp_count = 0;
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 8'h0;
		araddr = 8'h0;
		wdata = 32'h0;
		wstrb = 4'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_disabled();
		t_single();
		t_burst();
		t_load();
		finish_test();
	end
endmodule
`default_nettype wire
